// ---- logic/annp_pkg.sv ----
// Constants, field positions and types of the next page register bank.
// Assumes a 100 MHz clock and a clause 22 style management frame.
package annp_pkg;

  // Register offsets on the management bus
  localparam logic [4:0] ANNP_OFS_EXPANSION = 5'h06;
  localparam logic [4:0] ANNP_OFS_NP_TX = 5'h07;
  localparam logic [4:0] ANNP_OFS_NP_RX = 5'h08;
  localparam logic [4:0] ANNP_OFS_MS_CTRL = 5'h09;

  // Reset values
  localparam logic [15:0] ANNP_NP_TX_RESET = 16'h2001;
  localparam logic [15:0] ANNP_NP_RX_RESET = 16'h0000;
  localparam logic [15:0] ANNP_MS_CTRL_RESET = 16'h0200;

  // Next page word fields, same layout for both directions
  localparam int ANNP_NP_MORE_BIT = 15;
  localparam int ANNP_NP_ACK_BIT = 14;
  localparam int ANNP_NP_MSG_BIT = 13;
  localparam int ANNP_NP_COMPLY_BIT = 12;
  localparam int ANNP_TX_SYNC_TOGGLE_BIT = 11;
  localparam int ANNP_TX_CODE_FIELD_HI = 10;
  localparam logic [15:0] ANNP_NP_TX_WR_MASK = 16'hb7ff;

  // Master/slave control fields
  localparam int ANNP_MS_TEST_HI = 15;
  localparam int ANNP_MS_TEST_LO = 13;
  localparam logic [2:0] ANNP_TEST_RSVD_6 = 3'h6;
  localparam logic [2:0] ANNP_TEST_RSVD_7 = 3'h7;
  localparam logic [2:0] ANNP_TEST_NORMAL = 3'h0;
  localparam int ANNP_MS_MANUAL_BIT = 12;
  localparam int ANNP_MS_MASTER_BIT = 11;
  localparam int ANNP_MS_ADV1000_BIT = 9;
  localparam logic [1:0] ANNP_STRAP_WAIT = 2'h3;

  // Expansion register fields
  localparam int ANNP_EXP_LOC_ABLE_BIT = 6;
  localparam int ANNP_EXP_LOC_BIT = 5;
  localparam int ANNP_EXP_LP_NP_BIT = 3;
  localparam int ANNP_EXP_NP_ABLE_BIT = 2;
  localparam int ANNP_EXP_ARRIVED_BIT = 1;
  localparam int ANNP_EXP_LP_AN_BIT = 0;

  // Management frame
  localparam logic [5:0] ANNP_PREAMBLE_ONES = 6'h20;
  localparam logic [5:0] ANNP_HDR_LAST = 6'h0c;
  localparam logic [5:0] ANNP_DATA_LAST = 6'h0f;
  localparam logic [1:0] ANNP_OP_READ = 2'h2;
  localparam logic [1:0] ANNP_OP_WRITE = 2'h1;

  // Pin synchroniser width: mdc, mdio, phy address, three straps
  localparam int ANNP_SYNC_W = 10;

  typedef enum logic [4:0] {
    ANNP_S_PRE = 5'h01,
    ANNP_S_HDR = 5'h02,
    ANNP_S_TA = 5'h04,
    ANNP_S_WDATA = 5'h08,
    ANNP_S_RDATA = 5'h10
  } annp_mdio_state_e;

endpackage

// ---- logic/annp_pin_if.sv ----
// Synchronised pin levels passed from the pin synchroniser to the core.
// Assumes both ends run on the one system clock.
`timescale 1ns/100ps
interface annp_pin_if;
  logic mdc_rise;
  logic mdio_bit;
  logic [4:0] phy_addr;
  logic strap_manual;
  logic strap_master;
  logic strap_adv1000;

  modport sync (
    output mdc_rise,
    output mdio_bit,
    output phy_addr,
    output strap_manual,
    output strap_master,
    output strap_adv1000
  );

  modport core (
    input mdc_rise,
    input mdio_bit,
    input phy_addr,
    input strap_manual,
    input strap_master,
    input strap_adv1000
  );
endinterface

// ---- logic/annp_pin_sync.sv ----
// Two-flop synchronisers for all external pins plus the mdc rising edge.
// Assumes pins are asynchronous to clock; edge detect uses the second stage.
`timescale 1ns/100ps
module annp_pin_sync
  import annp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_i,
  input wire logic [4:0] phy_addr_pin,
  input wire logic strap_manual_ms,
  input wire logic strap_master,
  input wire logic strap_adv_1000,
  annp_pin_if.sync pins
);

  logic [ANNP_SYNC_W-1:0] raw;
  logic [ANNP_SYNC_W-1:0] meta_q;
  logic [ANNP_SYNC_W-1:0] sync_q;
  logic mdc_prev_q;

  assign raw = {strap_adv_1000, strap_master, strap_manual_ms, phy_addr_pin, mdio_i, mdc};

  for (genvar i = 0; i < ANNP_SYNC_W; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (rst) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= sync_q[0];
    end
  end

  assign pins.mdc_rise = sync_q[0] & ~mdc_prev_q;
  assign pins.mdio_bit = sync_q[1];
  assign pins.phy_addr = sync_q[6:2];
  assign pins.strap_manual = sync_q[7];
  assign pins.strap_master = sync_q[8];
  assign pins.strap_adv1000 = sync_q[9];

endmodule

// ---- logic/annp_next_page_regs.sv ----
// Next page register bank with its management frame slave.
// Assumes the arbitration logic runs on clock and pulses its strobes.
//
// Function
// - Transmit bit 15 writable; set means more next pages follow.
// - Transmit bit 13 writable, resets 1; set means message page.
// - Transmit bit 12 writable, resets 0; local device can comply.
// - Transmit bit 11 read only, inverse of previous exchanged toggle.
// - Transmit bits 10:0 writable eleven bit code, resets to 1.
// - Message flag clear means code bits are unformatted page content.
// - Transmit register at 0x0007, resets 0x2001, bit 14 reads zero.
// - Received register at 0x0008, resets zero, read only.
// - Received bit 15 shows partner sends further next pages.
// - Received bit 13 shows partner message or unformatted page.
// - Received bit 12 shows partner can comply with message.
// - Received bit 11 carries partner toggle value.
// - Received bits 10:0 hold partner eleven bit code.
// - Master/slave control at 0x0009, reset 0x0200 adjusted by straps.
// - Control bits 15:13 writable test select, reset 0; 110, 111 reserved.
// - Received next pages stored at 0x0008, not base page register.
// - Page arrived flag latches high until software reads it.
`timescale 1ns/100ps
module annp_next_page_regs
  import annp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr_pin,
  input wire logic strap_manual_ms,
  input wire logic strap_master,
  input wire logic strap_adv_1000,
  input wire logic arb_page_strobe,
  input wire logic arb_page_is_next,
  input wire logic [15:0] arb_page_word,
  input wire logic arb_toggle_load,
  input wire logic arb_toggle_prev,
  input wire logic arb_lp_np_able,
  input wire logic arb_lp_an_able,
  output logic [15:0] tx_page_word,
  output logic tx_page_loaded,
  output logic tx_page_unformatted,
  output logic rx_page_unformatted,
  output logic [2:0] transmitter_test_select,
  output logic page_arrived_latch
);

  annp_pin_if pins();

  annp_pin_sync u_sync (
    .clock(clock),
    .rst(rst),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .phy_addr_pin(phy_addr_pin),
    .strap_manual_ms(strap_manual_ms),
    .strap_master(strap_master),
    .strap_adv_1000(strap_adv_1000),
    .pins(pins)
  );

  // Frame engine state
  annp_mdio_state_e state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [11:0] hdr_q, hdr_d;
  logic [1:0] op_q, op_d;
  logic [4:0] reg_q, reg_d;
  logic [15:0] shift_q, shift_d;
  logic mdio_o_q, mdio_o_d;
  logic mdio_oe_q, mdio_oe_d;
  logic wr_fire;
  logic rd_take;

  // Register state
  logic [15:0] np_tx_q;
  logic toggle_q;
  logic [15:0] np_rx_q;
  logic [15:0] ms_ctrl_q;
  logic arrived_q;
  logic [1:0] strap_wait_q;
  logic strap_done_q;
  logic loaded_q;
  logic [2:0] test_sel_q;

  // Frame decode
  wire tick = pins.mdc_rise;
  wire bit_in = pins.mdio_bit;
  wire [12:0] hdr_full = {hdr_q, bit_in};
  wire hdr_start_ok = hdr_full[12];
  wire [1:0] hdr_op = hdr_full[11:10];
  wire [4:0] hdr_phy = hdr_full[9:5];
  wire [4:0] hdr_reg = hdr_full[4:0];
  wire hdr_op_ok = (hdr_op == ANNP_OP_READ) || (hdr_op == ANNP_OP_WRITE);
  wire hdr_accept = hdr_start_ok && hdr_op_ok && (hdr_phy == pins.phy_addr);
  wire is_read = (op_q == ANNP_OP_READ);
  wire preamble_full = (cnt_q == ANNP_PREAMBLE_ONES);
  wire [15:0] wr_data = {shift_q[14:0], bit_in};

  // Address decode
  wire sel_exp = (reg_q == ANNP_OFS_EXPANSION);
  wire sel_np_tx = (reg_q == ANNP_OFS_NP_TX);
  wire sel_np_rx = (reg_q == ANNP_OFS_NP_RX);
  wire sel_ms = (reg_q == ANNP_OFS_MS_CTRL);

  // Register views
  wire [15:0] np_tx_view = {np_tx_q[15], 1'b0, np_tx_q[13:12], toggle_q, np_tx_q[10:0]};
  wire [15:0] exp_view = (16'h0001 << ANNP_EXP_LOC_ABLE_BIT)
                       | (16'h0001 << ANNP_EXP_LOC_BIT)
                       | (16'h0001 << ANNP_EXP_NP_ABLE_BIT)
                       | ({15'h0000, arb_lp_np_able} << ANNP_EXP_LP_NP_BIT)
                       | ({15'h0000, arrived_q} << ANNP_EXP_ARRIVED_BIT)
                       | ({15'h0000, arb_lp_an_able} << ANNP_EXP_LP_AN_BIT);

  // Read mux; unmapped offsets read zero
  wire [15:0] rd_word = sel_exp ? exp_view :
                        sel_np_tx ? np_tx_view :
                        sel_np_rx ? np_rx_q :
                        sel_ms ? ms_ctrl_q : 16'h0000;

  // Write strobes
  wire wr_np_tx = wr_fire && sel_np_tx;
  wire wr_ms = wr_fire && sel_ms;
  wire clr_arrived = rd_take && sel_exp;
  wire rx_next_store = arb_page_strobe && arb_page_is_next;

  // Strap merge into the control word
  wire [15:0] strap_word = (ANNP_MS_CTRL_RESET
                           & ~(16'h0001 << ANNP_MS_MANUAL_BIT)
                           & ~(16'h0001 << ANNP_MS_MASTER_BIT)
                           & ~(16'h0001 << ANNP_MS_ADV1000_BIT))
                         | ({15'h0000, pins.strap_manual} << ANNP_MS_MANUAL_BIT)
                         | ({15'h0000, pins.strap_master} << ANNP_MS_MASTER_BIT)
                         | ({15'h0000, pins.strap_adv1000} << ANNP_MS_ADV1000_BIT);
  wire strap_apply = ~strap_done_q && (strap_wait_q == ANNP_STRAP_WAIT);

  // Test select with reserved codes held at normal operation
  wire [2:0] test_field = ms_ctrl_q[ANNP_MS_TEST_HI:ANNP_MS_TEST_LO];
  wire test_reserved = (test_field == ANNP_TEST_RSVD_6) || (test_field == ANNP_TEST_RSVD_7);
  wire [2:0] test_sel_d = test_reserved ? ANNP_TEST_NORMAL : test_field;

  // Frame sequencing
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    op_d = op_q;
    reg_d = reg_q;
    shift_d = shift_q;
    mdio_o_d = mdio_o_q;
    mdio_oe_d = mdio_oe_q;
    wr_fire = 1'b0;
    rd_take = 1'b0;
    if (tick) begin
      case (state_q)
        ANNP_S_PRE: begin
          if (bit_in) begin
            cnt_d = preamble_full ? cnt_q : cnt_q + 6'h01;
          end else if (preamble_full) begin
            state_d = ANNP_S_HDR;
            cnt_d = 6'h00;
          end else begin
            cnt_d = 6'h00;
          end
        end
        ANNP_S_HDR: begin
          hdr_d = hdr_full[11:0];
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == ANNP_HDR_LAST) begin
            cnt_d = 6'h00;
            op_d = hdr_op;
            reg_d = hdr_reg;
            state_d = hdr_accept ? ANNP_S_TA : ANNP_S_PRE;
          end
        end
        ANNP_S_TA: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h00) begin
            if (is_read) begin
              mdio_oe_d = 1'b1;
              mdio_o_d = 1'b0;
            end
          end else begin
            cnt_d = 6'h00;
            if (is_read) begin
              rd_take = 1'b1;
              shift_d = {rd_word[14:0], 1'b0};
              mdio_o_d = rd_word[15];
              state_d = ANNP_S_RDATA;
            end else begin
              state_d = ANNP_S_WDATA;
            end
          end
        end
        ANNP_S_RDATA: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == ANNP_DATA_LAST) begin
            cnt_d = 6'h00;
            mdio_oe_d = 1'b0;
            mdio_o_d = 1'b0;
            state_d = ANNP_S_PRE;
          end else begin
            mdio_o_d = shift_q[15];
            shift_d = {shift_q[14:0], 1'b0};
          end
        end
        ANNP_S_WDATA: begin
          cnt_d = cnt_q + 6'h01;
          shift_d = wr_data;
          if (cnt_q == ANNP_DATA_LAST) begin
            cnt_d = 6'h00;
            wr_fire = 1'b1;
            state_d = ANNP_S_PRE;
          end
        end
        default: begin
          state_d = ANNP_S_PRE;
          cnt_d = 6'h00;
          mdio_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ANNP_S_PRE;
      cnt_q <= 6'h00;
      hdr_q <= 12'h000;
      op_q <= 2'h0;
      reg_q <= 5'h00;
      shift_q <= 16'h0000;
      mdio_o_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      op_q <= op_d;
      reg_q <= reg_d;
      shift_q <= shift_d;
      mdio_o_q <= mdio_o_d;
      mdio_oe_q <= mdio_oe_d;
    end
  end

  // Local next page word; reserved bit and toggle never stored here
  always_ff @(posedge clock) begin
    if (rst) begin
      np_tx_q <= ANNP_NP_TX_RESET & ANNP_NP_TX_WR_MASK;
    end else if (wr_np_tx) begin
      np_tx_q <= wr_data & ANNP_NP_TX_WR_MASK;
    end
  end

  // Toggle follows the arbitration, inverted from the last exchanged word
  always_ff @(posedge clock) begin
    if (rst) begin
      toggle_q <= 1'b0;
    end else if (arb_toggle_load) begin
      toggle_q <= ~arb_toggle_prev;
    end
  end

  // Partner next page capture; base pages only raise the arrival flag
  always_ff @(posedge clock) begin
    if (rst) begin
      np_rx_q <= ANNP_NP_RX_RESET;
    end else if (rx_next_store) begin
      np_rx_q <= arb_page_word;
    end
  end

  // Arrival flag: a new page wins over the clearing read
  always_ff @(posedge clock) begin
    if (rst) begin
      arrived_q <= 1'b0;
    end else if (arb_page_strobe) begin
      arrived_q <= 1'b1;
    end else if (clr_arrived) begin
      arrived_q <= 1'b0;
    end
  end

  // Straps settle through the synchroniser before they are taken
  always_ff @(posedge clock) begin
    if (rst) begin
      strap_wait_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (~strap_done_q) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      strap_done_q <= strap_apply;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ms_ctrl_q <= ANNP_MS_CTRL_RESET;
    end else if (wr_ms) begin
      ms_ctrl_q <= wr_data;
    end else if (strap_apply) begin
      ms_ctrl_q <= strap_word;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      test_sel_q <= ANNP_TEST_NORMAL;
      loaded_q <= 1'b0;
    end else begin
      test_sel_q <= test_sel_d;
      loaded_q <= wr_np_tx;
    end
  end

  assign mdio_o = mdio_o_q;
  assign mdio_oe = mdio_oe_q;
  assign tx_page_word = np_tx_view;
  assign tx_page_loaded = loaded_q;
  assign tx_page_unformatted = ~np_tx_q[ANNP_NP_MSG_BIT];
  assign rx_page_unformatted = ~np_rx_q[ANNP_NP_MSG_BIT];
  assign transmitter_test_select = test_sel_q;
  assign page_arrived_latch = arrived_q;

endmodule

// ---- verif/annp_np_assertions.sv ----
// Port checks for the next page register bank, bound to its top module.
// Assumes one clock domain and the synchronous active high reset.
`timescale 1ns/100ps
module annp_np_assertions
  import annp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic mdio_oe,
  input wire logic arb_page_strobe,
  input wire logic arb_page_is_next,
  input wire logic [15:0] arb_page_word,
  input wire logic arb_toggle_load,
  input wire logic arb_toggle_prev,
  input wire logic [15:0] tx_page_word,
  input wire logic tx_page_unformatted,
  input wire logic rx_page_unformatted,
  input wire logic [2:0] transmitter_test_select,
  input wire logic page_arrived_latch
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire logic rx_msg = arb_page_word[ANNP_NP_MSG_BIT];

  property p_tx_unf;
    tx_page_unformatted == !tx_page_word[ANNP_NP_MSG_BIT];
  endproperty
  a_tx_unf: assert property (p_tx_unf) else $error("tx unformatted flag wrong");
  property p_rx_unf;
    arb_page_strobe && arb_page_is_next |=> rx_page_unformatted != $past(rx_msg);
  endproperty
  a_rx_unf: assert property (p_rx_unf) else $error("rx unformatted flag wrong");
  property p_latch_set;
    arb_page_strobe |=> page_arrived_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("page latch not set");
  property p_latch_hold;
    page_arrived_latch && !mdio_oe |=> page_arrived_latch;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("page latch dropped");
  property p_toggle;
    arb_toggle_load |=> tx_page_word[ANNP_TX_SYNC_TOGGLE_BIT] == !$past(arb_toggle_prev);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not inverse");
  property p_toggle_hold;
    !arb_toggle_load |=> $stable(tx_page_word[ANNP_TX_SYNC_TOGGLE_BIT]);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved");
  property p_test_sel;
    transmitter_test_select != ANNP_TEST_RSVD_6 && transmitter_test_select != ANNP_TEST_RSVD_7;
  endproperty
  a_test_sel: assert property (p_test_sel) else $error("reserved test code out");
  property p_rst_vals;
    $fell(rst) |-> tx_page_word == ANNP_NP_TX_RESET && !page_arrived_latch
      && transmitter_test_select == ANNP_TEST_NORMAL;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  c_next: cover property (arb_page_strobe && arb_page_is_next);
  c_toggle: cover property (arb_toggle_load ##1 tx_page_word[ANNP_TX_SYNC_TOGGLE_BIT]);
  c_clear: cover property ($fell(page_arrived_latch));
endmodule

bind annp_next_page_regs annp_np_assertions u_chk (
  .clock(clock), .rst(rst), .mdio_oe(mdio_oe), .arb_page_strobe(arb_page_strobe),
  .arb_page_is_next(arb_page_is_next), .arb_page_word(arb_page_word),
  .arb_toggle_load(arb_toggle_load), .arb_toggle_prev(arb_toggle_prev),
  .tx_page_word(tx_page_word), .tx_page_unformatted(tx_page_unformatted),
  .rx_page_unformatted(rx_page_unformatted),
  .transmitter_test_select(transmitter_test_select), .page_arrived_latch(page_arrived_latch)
);

// ---- verif/annp_mdio_host.sv ----
// Management host model: clause 22 frames on mdc and mdio.
// Assumes the bench resolves the shared line with a pull-up.
`timescale 1ns/100ps
module annp_mdio_host
  import annp_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h03
)
(
  input wire logic clock,
  input wire logic line,
  output logic mdc,
  output logic drv_oe,
  output logic drv_bit
);
  initial begin
    mdc = 1'b0;
    drv_oe = 1'b0;
    drv_bit = 1'b1;
  end
  // One mdc period of 20 clocks, line sampled just before the rise
  task automatic tick(input logic oe, input logic b, output logic s);
    drv_oe = oe;
    drv_bit = b;
    repeat (10) @(negedge clock);
    s = line;
    mdc = 1'b1;
    repeat (10) @(negedge clock);
    mdc = 1'b0;
  endtask
  // Fresh preamble each frame, line released over turnaround on reads
  task automatic frame(input logic [1:0] op, input logic [4:0] ad,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic s;
    logic wr;
    hdr = {32'hffffffff, 2'b01, op, PHY_ADDR, ad};
    wr = (op == ANNP_OP_WRITE);
    for (int i = 45; i >= 0; i--)
      tick(1'b1, hdr[i], s);
    tick(wr, 1'b1, s);
    tick(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      tick(wr, wd[i], s);
      rd[i] = s;
    end
    tick(1'b0, 1'b1, s);
  endtask
endmodule

// ---- verif/annp_next_page_regs_tb.sv ----
// Bench for the next page register bank, driven through management frames.
// Assumes the host model and the bound port checker.
`timescale 1ns/100ps
module annp_next_page_regs_tb;
  import annp_pkg::*;
  logic clock, rst, mdc, mdio_o, mdio_oe, h_oe, h_bit, line;
  logic s_man, s_mst, s_adv, np_able, an_able, strobe, is_next, tload, tprev;
  logic tx_ld, tx_unf, rx_unf, latch;
  logic [15:0] word, txw, rd, x;
  logic [2:0] tsel;
  int mismatches, n_tests, loads;
  // Pulled-up shared data line
  assign line = mdio_oe ? mdio_o : (h_oe ? h_bit : 1'b1);

  annp_mdio_host host (.clock(clock), .line(line), .mdc(mdc), .drv_oe(h_oe), .drv_bit(h_bit));
  // Counts one-cycle load pulses of the transmit page
  always @(negedge clock) begin
    if (tx_ld === 1'b1) begin
      loads++;
    end
  end
  annp_next_page_regs uut (
    .clock(clock), .rst(rst), .mdc(mdc), .mdio_i(line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .phy_addr_pin(5'h03), .strap_manual_ms(s_man), .strap_master(s_mst),
    .strap_adv_1000(s_adv), .arb_page_strobe(strobe), .arb_page_is_next(is_next),
    .arb_page_word(word), .arb_toggle_load(tload), .arb_toggle_prev(tprev),
    .arb_lp_np_able(np_able), .arb_lp_an_able(an_able), .tx_page_word(txw),
    .tx_page_loaded(tx_ld), .tx_page_unformatted(tx_unf), .rx_page_unformatted(rx_unf),
    .transmitter_test_select(tsel), .page_arrived_latch(latch)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    host.frame(ANNP_OP_READ, a, 16'h0000, rd);
    check("read", rd, exp);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    host.frame(ANNP_OP_WRITE, a, d, x);
  endtask
  task automatic page(input logic nx, input logic [15:0] w);
    is_next = nx;
    word = w;
    strobe = 1'b1;
    @(negedge clock);
    strobe = 1'b0;
    @(negedge clock);
  endtask
  task automatic toggle(input logic p);
    tprev = p;
    tload = 1'b1;
    @(negedge clock);
    tload = 1'b0;
    @(negedge clock);
  endtask
  task automatic results;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    results;
  end

  initial begin
    {rst, s_man, s_mst, s_adv, np_able, an_able} = 6'b110110;
    loads = 0;
    {strobe, is_next, tload, tprev} = 4'h0;
    word = 16'h0000;
    mismatches = 0;
    n_tests = 0;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    check("tx word", txw, ANNP_NP_TX_RESET);
    check("flags", 16'({tx_unf, rx_unf, latch, tsel}), 16'h0010);
    rd_chk(ANNP_OFS_NP_TX, 16'h2001);
    rd_chk(ANNP_OFS_NP_RX, 16'h0000);
    rd_chk(ANNP_OFS_MS_CTRL, 16'h1200);
    wr_reg(ANNP_OFS_NP_TX, 16'hffff);
    rd_chk(ANNP_OFS_NP_TX, 16'hb7ff);
    wr_reg(ANNP_OFS_NP_TX, 16'h0000);
    check("tx unf", 16'(tx_unf), 16'h0001);
    rd_chk(ANNP_OFS_NP_TX, 16'h0000);
    toggle(1'b0);
    check("toggle", txw, 16'h0800);
    toggle(1'b1);
    check("toggle", txw, 16'h0000);
    // Writes to read-only and unmapped places are ignored
    wr_reg(ANNP_OFS_NP_RX, 16'hffff);
    wr_reg(5'h0a, 16'hffff);
    rd_chk(ANNP_OFS_NP_RX, 16'h0000);
    rd_chk(5'h0a, 16'h0000);
    page(1'b1, 16'hf805);
    check("rx unf", 16'(rx_unf), 16'h0000);
    rd_chk(ANNP_OFS_NP_RX, 16'hf805);
    check("rx masked", rd & 16'hbfff, 16'hb805);
    page(1'b0, 16'h1234);
    check("latch", 16'(latch), 16'h0001);
    rd_chk(ANNP_OFS_NP_RX, 16'hf805);
    rd_chk(ANNP_OFS_EXPANSION, 16'h006e);
    rd_chk(ANNP_OFS_EXPANSION, 16'h006c);
    wr_reg(ANNP_OFS_NP_TX, 16'h8005);
    check("tx word", txw, 16'h8005);
    page(1'b1, 16'h0123);
    check("rx unf", 16'(rx_unf), 16'h0001);
    rd_chk(ANNP_OFS_NP_RX, 16'h0123);
    for (int t = 0; t < 8; t++) begin
      wr_reg(ANNP_OFS_MS_CTRL, {3'(t), 13'h0200});
      check("test sel", 16'(tsel), (t >= 6) ? 16'h0000 : 16'(t));
    end
    rd_chk(ANNP_OFS_MS_CTRL, 16'he200);
    check("loads", 16'(loads), 16'h0003);
    results;
  end
endmodule
